/* File: sme_pkg.sv */
// shared constants and types for the spi master shift engine
package sme_pkg;
    localparam int CLK_NS = 50;
    localparam int SCK_HALF_NS = 200;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int HALF_MIN = 3;
    localparam logic [3:0] LEN_MIN = 4'h1;
    localparam logic [3:0] LEN_MAX = 4'h8;
    localparam logic [7:0] RX_RST = 8'h00;
    localparam logic SS_N_RST = 1'b1;
    localparam logic SCK_RST = 1'b0;
    localparam logic MOSI_RST = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LEAD = 3'b001,
        ST_SHIFT = 3'b010,
        ST_TRAIL = 3'b011,
        ST_EXTRA = 3'b100,
        ST_GAP = 3'b101
    } sme_state_t;

    typedef struct packed {
        logic cpol;
        logic cpha;
        logic lsb_first_select;
        logic ss_hold;
        logic [3:0] len;
        logic [7:0] extra;
    } sme_cfg_t;
endpackage

/* File: sme_sync.sv */
// two-flop synchroniser for levels entering the system clock domain
`timescale 1ns/1ps
module sme_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule

/* File: sme_spi_master.sv */
// spi master shift engine: framing, clock generation and full-duplex shift
//
// Contract
// - each shift lasts a programmed 1 to 8 serial clocks.
// - optional hold keeps slave select low across consecutive transfers.
// - optional preset count of extra serial clocks after slave select rises.
// - every bit time drives one MOSI bit and captures one MISO bit.
// - a single slave select line picks the one addressed slave.
// - polarity bit sets idle clock level; phase bit picks transfer format.
// - phase 0: first clock edge half period after select falls, samples.
// - phase 0: two edges per bit (sixteen at length 8), sample on odd, shift and drive on even.
// - bit order 0 sends and assembles msb first, 1 lsb first.
// - received word copied to data register only after last bit.
// - done flag set after the last clock edge.
// - after a transfer, tx word went out, slave word sits in data register.
// - lead, trail and idle gap each at least half a serial clock period.
// - phase 1: first edge after half-period delay only prompts slave; second samples.
// - phase 1: two edges per bit (sixteen at length 8), sample on even, shift and drive on odd.
// - phase 1 back-to-back transfers skip lead and idle gap, keep trail.
// - the block's own slave select pin is held high in master mode.
// - twelve-bit result read as a four-clock shift then an eight-clock shift.
`timescale 1ns/1ps
module sme_spi_master #(
    parameter int HALF_CYC = sme_pkg::SCK_HALF_CYC
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic START_I,
    input wire logic [7:0] TX_DATA_I,
    input wire sme_pkg::sme_cfg_t CFG_I,
    input wire logic DONE_CLEAR_I,
    input wire logic MISO_I,
    output logic SCK_O,
    output logic MOSI_O,
    output logic SS_N_O,
    output logic OWN_SS_N_O,
    output logic [7:0] RX_DATA_O,
    output logic TRANSFER_DONE_FLAG_O,
    output logic BUSY_O
);
    sme_pkg::sme_state_t state;
    sme_pkg::sme_state_t next_state;
    sme_pkg::sme_cfg_t cfg;
    sme_pkg::sme_cfg_t next_cfg;
    logic [7:0] hcnt;
    logic [7:0] next_hcnt;
    logic [8:0] ecnt;
    logic [8:0] next_ecnt;
    logic [3:0] bitn;
    logic [3:0] next_bitn;
    logic [7:0] tx;
    logic [7:0] next_tx;
    logic [7:0] rx;
    logic [7:0] next_rx;
    logic next_sck;
    logic next_mosi;
    logic next_ss_n;
    logic [7:0] next_rx_data;
    logic next_done;
    logic done_set;
    logic tick;
    logic sample_edge;
    logic miso_s;
    sme_pkg::sme_cfg_t start_cfg;

    // miso needs three cycles of margin before a sampling edge; the half-period counter is eight bits
    if (HALF_CYC < sme_pkg::HALF_MIN || HALF_CYC > 255) begin : g_bad_half
        $error("HALF_CYC out of range");
    end

    // MISO is asynchronous to the system clock
    sme_sync #(.W(1)) u_miso_sync (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .d_i(MISO_I),
        .q_o(miso_s)
    );

    function automatic logic [2:0] bit_idx(input logic lsb, input logic [3:0] len, input logic [3:0] b);
        logic [3:0] t;
        t = lsb ? b : 4'(len - 4'h1 - b);
        return t[2:0];
    endfunction

    function automatic sme_pkg::sme_cfg_t fix_len(input sme_pkg::sme_cfg_t c);
        sme_pkg::sme_cfg_t r;
        r = c;
        if (c.len < sme_pkg::LEN_MIN || c.len > sme_pkg::LEN_MAX) begin
            r.len = sme_pkg::LEN_MAX;
        end
        return r;
    endfunction

    assign tick = (hcnt == 8'(HALF_CYC - 1));
    // odd-numbered edge is the one made while ecnt is even
    assign sample_edge = ~ecnt[0] ^ cfg.cpha;
    assign start_cfg = fix_len(CFG_I);

    always_comb begin
        next_state = state;
        next_cfg = cfg;
        next_ecnt = ecnt;
        next_bitn = bitn;
        next_tx = tx;
        next_rx = rx;
        next_sck = SCK_O;
        next_mosi = MOSI_O;
        next_ss_n = SS_N_O;
        next_rx_data = RX_DATA_O;
        done_set = 1'b0;
        case (state)
            sme_pkg::ST_IDLE: begin
                if (SS_N_O) begin
                    next_sck = CFG_I.cpol;
                end
                if (START_I) begin
                    next_cfg = start_cfg;
                    next_tx = TX_DATA_I;
                    next_rx = sme_pkg::RX_RST;
                    next_ecnt = '0;
                    next_bitn = '0;
                    next_ss_n = 1'b0;
                    if (!SS_N_O && CFG_I.cpha) begin
                        next_state = sme_pkg::ST_SHIFT;
                    end else begin
                        next_state = sme_pkg::ST_LEAD;
                    end
                    if (!CFG_I.cpha) begin
                        next_mosi = TX_DATA_I[bit_idx(CFG_I.lsb_first_select, start_cfg.len, 4'h0)];
                    end
                end else if (!SS_N_O && !CFG_I.ss_hold) begin
                    // held frame released: go through trail and deselect
                    next_cfg.ss_hold = 1'b0;
                    next_cfg.extra = CFG_I.extra;
                    next_state = sme_pkg::ST_TRAIL;
                end
            end
            sme_pkg::ST_LEAD: begin
                next_state = sme_pkg::ST_SHIFT;
            end
            sme_pkg::ST_SHIFT: begin
                if (tick) begin
                    next_sck = ~SCK_O;
                    next_ecnt = 9'(ecnt + 9'h001);
                    if (sample_edge) begin
                        next_rx[bit_idx(cfg.lsb_first_select, cfg.len, bitn)] = miso_s;
                        if (cfg.cpha) begin
                            next_bitn = 4'(bitn + 4'h1);
                        end
                    end else if (!cfg.cpha) begin
                        next_bitn = 4'(bitn + 4'h1);
                        if (4'(bitn + 4'h1) < cfg.len) begin
                            next_mosi = tx[bit_idx(cfg.lsb_first_select, cfg.len, 4'(bitn + 4'h1))];
                        end
                    end else begin
                        next_mosi = tx[bit_idx(cfg.lsb_first_select, cfg.len, bitn)];
                    end
                    if (next_ecnt == {4'h0, cfg.len, 1'b0}) begin
                        done_set = 1'b1;
                        next_state = sme_pkg::ST_TRAIL;
                    end
                end
            end
            sme_pkg::ST_TRAIL: begin
                if (tick) begin
                    next_ecnt = '0;
                    if (cfg.ss_hold) begin
                        next_state = sme_pkg::ST_IDLE;
                    end else begin
                        next_ss_n = 1'b1;
                        if (cfg.extra != 8'h00) begin
                            next_state = sme_pkg::ST_EXTRA;
                        end else begin
                            next_state = sme_pkg::ST_GAP;
                        end
                    end
                end
            end
            sme_pkg::ST_EXTRA: begin
                if (tick) begin
                    next_sck = ~SCK_O;
                    next_ecnt = 9'(ecnt + 9'h001);
                    if (next_ecnt == {cfg.extra, 1'b0}) begin
                        next_state = sme_pkg::ST_GAP;
                    end
                end
            end
            sme_pkg::ST_GAP: begin
                if (tick) begin
                    next_state = sme_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = sme_pkg::ST_IDLE;
                next_ss_n = 1'b1;
            end
        endcase
        if (done_set) begin
            next_rx_data = next_rx;
        end
        next_done = done_set | (TRANSFER_DONE_FLAG_O & ~DONE_CLEAR_I);
        next_hcnt = (tick || next_state != state) ? 8'h00 : 8'(hcnt + 8'h01);
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state <= sme_pkg::ST_IDLE;
            cfg <= '0;
            hcnt <= '0;
            ecnt <= '0;
            bitn <= '0;
            tx <= '0;
            rx <= sme_pkg::RX_RST;
            SCK_O <= sme_pkg::SCK_RST;
            MOSI_O <= sme_pkg::MOSI_RST;
            SS_N_O <= sme_pkg::SS_N_RST;
            OWN_SS_N_O <= 1'b1;
            RX_DATA_O <= sme_pkg::RX_RST;
            TRANSFER_DONE_FLAG_O <= 1'b0;
            BUSY_O <= 1'b0;
        end else begin
            state <= next_state;
            cfg <= next_cfg;
            hcnt <= next_hcnt;
            ecnt <= next_ecnt;
            bitn <= next_bitn;
            tx <= next_tx;
            rx <= next_rx;
            SCK_O <= next_sck;
            MOSI_O <= next_mosi;
            SS_N_O <= next_ss_n;
            OWN_SS_N_O <= 1'b1;
            RX_DATA_O <= next_rx_data;
            TRANSFER_DONE_FLAG_O <= next_done;
            BUSY_O <= (next_state != sme_pkg::ST_IDLE);
        end
    end

    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (RST_I);

    property p_len;
        done_set |-> ecnt == 9'({cfg.len, 1'b0} - 5'h01);
    endproperty
    a_len: assert property (p_len) else $error("edge count wrong at end of shift");

    property p_hold;
        state == sme_pkg::ST_TRAIL && tick && cfg.ss_hold |=> !SS_N_O && !BUSY_O;
    endproperty
    a_hold: assert property (p_hold) else $error("select not held after transfer");

    property p_extra;
        state == sme_pkg::ST_EXTRA |-> SS_N_O;
    endproperty
    a_extra: assert property (p_extra) else $error("extra clocks with select low");

    property p_lead;
        $fell(SS_N_O) |-> $stable(SCK_O)[*3];
    endproperty
    a_lead: assert property (p_lead) else $error("clock edge too soon after select");

    property p_rest;
        !BUSY_O && !SS_N_O |=> $stable(SCK_O);
    endproperty
    a_rest: assert property (p_rest) else $error("clock moved while frame held");

    property p_rxcopy;
        $changed(RX_DATA_O) |-> $past(done_set);
    endproperty
    a_rxcopy: assert property (p_rxcopy) else $error("data register changed mid transfer");

    property p_idle_level;
        $rose(TRANSFER_DONE_FLAG_O) |-> SCK_O == cfg.cpol;
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("clock not at idle level after last edge");

    property p_own_ss;
        $rose(BUSY_O) |-> OWN_SS_N_O ##1 OWN_SS_N_O;
    endproperty
    a_own_ss: assert property (p_own_ss) else $error("own select pin not high");

    property p_b2b;
        state == sme_pkg::ST_IDLE && START_I && !SS_N_O && CFG_I.cpha |=> state == sme_pkg::ST_SHIFT && !SS_N_O;
    endproperty
    a_b2b: assert property (p_b2b) else $error("back to back phase 1 not immediate");

    property p_start;
        state == sme_pkg::ST_IDLE && START_I |=> BUSY_O && !SS_N_O;
    endproperty
    a_start: assert property (p_start) else $error("start did not select the slave");

    property p_trail;
        $rose(TRANSFER_DONE_FLAG_O) |-> !SS_N_O [*3];
    endproperty
    a_trail: assert property (p_trail) else $error("select rose too soon after last edge");

    property p_gap;
        $rose(SS_N_O) |-> SS_N_O [*3];
    endproperty
    a_gap: assert property (p_gap) else $error("select idle gap too short");
endmodule

/* File: sme_slave_model.sv */
// behavioural spi slave facing the shift engine
`timescale 1ns/1ps
module sme_slave_model (
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic ss_n_i,
    input wire sme_pkg::sme_cfg_t cfg_i,
    input wire logic [7:0] tx_i,
    output logic miso_o,
    output logic [7:0] rx_o,
    output logic [7:0] edges_o,
    output logic [7:0] post_o
);
    logic [3:0] idx = 4'h0;
    function automatic logic pick(input logic [3:0] k);
        return cfg_i.lsb_first_select ? tx_i[k] : tx_i[cfg_i.len - 4'h1 - k];
    endfunction
    function automatic logic [3:0] nxt(input logic [3:0] k);
        return (k + 4'h1 == cfg_i.len) ? 4'h0 : k + 4'h1;
    endfunction
    initial begin
        miso_o = 1'b0;
        rx_o = 8'h00;
        edges_o = 8'h00;
        post_o = 8'h00;
    end
    always @(negedge ss_n_i) begin
        idx = 4'h0;
        edges_o = 8'h00;
        post_o = 8'h00;
        if (!cfg_i.cpha)
            miso_o = pick(4'h0);
    end
    // a released line must not keep showing the last bit
    always @(posedge ss_n_i) miso_o = ~miso_o;
    always @(sck_i) begin
        if (ss_n_i)
            post_o = post_o + 8'h1;
        else begin
            edges_o = edges_o + 8'h1;
            if ((sck_i !== cfg_i.cpol) ^ cfg_i.cpha)
                rx_o = {rx_o[6:0], mosi_i};
            else if (cfg_i.cpha) begin
                miso_o = pick(idx);
                idx = nxt(idx);
            end else begin
                idx = nxt(idx);
                miso_o = pick(idx);
            end
        end
    end
endmodule

/* File: tb_top.sv */
// self-checking bench for the spi master shift engine
`timescale 1ns/1ps
module tb_top;
    localparam int H = sme_pkg::SCK_HALF_CYC;
    logic clk = 1'b0, rst = 1'b1, start = 1'b0, clr = 1'b0;
    logic [7:0] tx = 8'h00, stx = 8'h00;
    sme_pkg::sme_cfg_t cfg = '0, scfg = '0;
    logic sck, mosi, ss_n, own_ss_n, flag, busy, miso;
    logic [7:0] rx, srx, edges, post;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    always #25 clk = ~clk;
    sme_spi_master i_sme_spi_master (.SYS_CLK_I(clk), .RST_I(rst), .START_I(start), .TX_DATA_I(tx),
        .CFG_I(cfg), .DONE_CLEAR_I(clr), .MISO_I(miso), .SCK_O(sck), .MOSI_O(mosi), .SS_N_O(ss_n),
        .OWN_SS_N_O(own_ss_n), .RX_DATA_O(rx), .TRANSFER_DONE_FLAG_O(flag), .BUSY_O(busy));
    sme_slave_model i_sme_slave_model (.sck_i(sck), .mosi_i(mosi), .ss_n_i(ss_n), .cfg_i(scfg),
        .tx_i(stx), .miso_o(miso), .rx_o(srx), .edges_o(edges), .post_o(post));
    function automatic logic [7:0] order(input logic [7:0] v, input int n, input logic lsb);
        order = 8'h00;
        for (int k = 0; k < n; k++)
            order[k] = lsb ? v[n-1-k] : v[k];
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            n_errors++;
            complete_run();
        end
    end
    task automatic prep(input sme_pkg::sme_cfg_t c);
        int k;
        @(posedge clk);
        cfg <= c;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while ((ss_n !== 1'b1 || busy !== 1'b0 || k < 2) && k < 100);
    endtask
    // poke: a second start with another length while busy must be ignored
    task automatic xfer(input sme_pkg::sme_cfg_t c, input logic [7:0] t, input logic [7:0] s,
                        input int exp, input bit poke);
        int lat;
        @(posedge clk);
        cfg <= c;
        scfg <= c;
        tx <= t;
        stx <= s;
        start <= 1'b1;
        lat = 0;
        do begin
            @(posedge clk);
            start <= poke && lat == 9;
            if (poke && lat == 9)
                cfg.len <= 4'h2;
            #1;
            lat++;
        end while (flag !== 1'b1 && lat < 400);
        check(8'(lat), 8'(exp));
        check(rx, s & order(8'hff, int'(c.len), 1'b0));
        check(srx & order(8'hff, int'(c.len), 1'b0), order(t, int'(c.len), c.lsb_first_select));
    endtask
    task automatic settle(input int gap);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            clr <= (k == 0);
            #1;
            k++;
        end while (busy !== 1'b0 && k < 400);
        if (gap > 0)
            check(8'(k), 8'(gap));
        check({7'h0, flag}, 8'h00);
    endtask
    initial begin
        sme_pkg::sme_cfg_t c;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check({4'h0, own_ss_n, ss_n, busy, flag}, 8'h0c);
        check(rx, 8'h00);
        for (int m = 0; m < 8; m++) begin
            c = '0;
            c.cpol = m[0];
            c.cpha = m[1];
            c.lsb_first_select = m[2];
            c.len = 4'(m + 1);
            prep(c);
            xfer(c, 8'h35 + 8'(m * 29), 8'hc6 - 8'(m * 17), 2 + 2 * (m + 1) * H, m == 7);
            check(edges, 8'(2 * m + 2));
            settle(2 * H);
            check({7'h0, sck}, {7'h0, c.cpol});
        end
        c = '0;
        c.cpol = 1'b1;
        c.cpha = 1'b1;
        c.ss_hold = 1'b1;
        c.len = 4'h4;
        prep(c);
        xfer(c, 8'h09, 8'h0b, 2 + 8 * H, 1'b0);
        settle(0);
        check({7'h0, ss_n}, 8'h00);
        c.len = 4'h8;
        xfer(c, 8'h5c, 8'he7, 1 + 16 * H, 1'b0);
        check(edges, 8'd24);
        settle(0);
        c.ss_hold = 1'b0;
        prep(c);
        c = '0;
        c.len = 4'h8;
        c.extra = 8'h03;
        prep(c);
        xfer(c, 8'ha5, 8'h3c, 2 + 16 * H, 1'b0);
        settle(0);
        check(post, 8'h06);
        check({6'h0, own_ss_n, ss_n}, 8'h03);
        complete_run();
    end
endmodule
